// ### hdl/csu_clock_synthesis.sv
// Clock synthesis unit: source select, postscaler, system clocks, registers
//
// Contract
// - The postscaler divides the selected clock by 1, 2, 4 up to 256.
// - The system clock is the postscaler output divided by two, 50% duty.
// - Timers and serial ports get a clock at twice the system clock rate.
// - Software powers down the relaxation and crystal oscillators separately.
// - Software can power down the PLL.
// - The relaxation oscillator has run, standby and power-down states.
// - Loss of the PLL reference shuts down PLL-derived clocking.
// - After reset the relaxation oscillator is selected and enabled.
// - A ten-bit trim sits in bits 9..0 of the oscillator control register.
// - Each trim step moves the oscillator by about 0.078% of 8 MHz.
// - The factory trim is loaded into flash option register 0 at reset.
// - The clock pin is the reference only with external select, mode set.
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`include "csu_cfg.svh"

module csu_clock_synthesis #(
	parameter int LOSS_CYCLES = `CSU_LOSS_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic                 relax_osc_clk,
	input  wire logic                 xtal_osc_clk,
	input  wire logic                 external_clock_pin,
	input  wire logic                 pll_clk,
	input  wire logic                 port_b_peripheral_enable,
	input  wire logic                 pin_function_select_c0,
	input  wire logic [9:0]           flash_trim_value,
	output logic                      relax_osc_power_down,
	output logic                      relax_osc_standby,
	output logic                      xtal_osc_power_down,
	output logic                      pll_power_down,
	output logic      [9:0]           relax_osc_trim,
	output logic                      external_clock_route,
	output csu_pkg::csu_src_type      active_source,
	output logic                      sys_clk,
	output logic                      sys_clk_2x,
	output logic                      ref_lost,
	output logic                      irq
);
	import csu_pkg::*;

	localparam logic [9:0] LOSS_CNT = 10'(LOSS_CYCLES);

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wdat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = wdat[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Register word to and from the PLL control fields
	function automatic logic [31:0] pll_pack(input csu_pll_ctrl_type p);
		logic [31:0] w;
		w = 32'h0;
		w[`CSU_PLL_REF_SEL] = p.ref_sel;
		w[`CSU_PLL_USE] = p.pll_use;
		w[`CSU_PLL_PD] = p.pll_pd;
		w[`CSU_PLL_RATIO_MSB:`CSU_PLL_RATIO_LSB] = p.ratio;
		return w;
	endfunction

	function automatic csu_pll_ctrl_type pll_unpack(input logic [31:0] w);
		csu_pll_ctrl_type p;
		p.ref_sel = w[`CSU_PLL_REF_SEL];
		p.pll_use = w[`CSU_PLL_USE];
		p.pll_pd = w[`CSU_PLL_PD];
		p.ratio = w[`CSU_PLL_RATIO_MSB:`CSU_PLL_RATIO_LSB];
		return p;
	endfunction

	// Register word to and from the oscillator control fields
	function automatic logic [31:0] osc_pack(input csu_osc_ctrl_type o);
		logic [31:0] w;
		w = 32'h0;
		w[`CSU_OSC_TRIM_MSB:`CSU_OSC_TRIM_LSB] = o.trim;
		w[`CSU_OSC_RELAX_PD] = o.relax_pd;
		w[`CSU_OSC_RELAX_SB] = o.relax_sb;
		w[`CSU_OSC_XTAL_PD] = o.xtal_pd;
		w[`CSU_OSC_EXTERNAL_SOURCE_SELECT] = o.external_source_select;
		w[`CSU_OSC_CLK_MODE] = o.clk_mode;
		return w;
	endfunction

	function automatic csu_osc_ctrl_type osc_unpack(input logic [31:0] w);
		csu_osc_ctrl_type o;
		o.trim = w[`CSU_OSC_TRIM_MSB:`CSU_OSC_TRIM_LSB];
		o.relax_pd = w[`CSU_OSC_RELAX_PD];
		o.relax_sb = w[`CSU_OSC_RELAX_SB];
		o.xtal_pd = w[`CSU_OSC_XTAL_PD];
		o.external_source_select = w[`CSU_OSC_EXTERNAL_SOURCE_SELECT];
		o.clk_mode = w[`CSU_OSC_CLK_MODE];
		return o;
	endfunction

	// Terminal count: source edges per half period of the double-rate clock, less one
	function automatic logic [8:0] post_term(input logic [3:0] ratio);
		return 9'((9'h1 << ratio) - 9'h1);
	endfunction

	csu_pll_ctrl_type        pll_q;
	csu_osc_ctrl_type        osc_q;
	csu_clk_cfg_type         act_q;
	csu_clk_cfg_type         req;
	csu_src_type             ref_src;
	logic [3:0]              sy1_q;
	logic [3:0]              sy2_q;
	logic [3:0]              sy3_q;
	logic [3:0]              edg;
	logic [9:0]              opt0_q;
	logic                    opt_loaded_q;
	logic [`CSU_EV_W-1:0]    stat_q;
	logic [`CSU_EV_W-1:0]    en_q;
	logic [`CSU_EV_W-1:0]    ev;
	logic [`CSU_EV_W-1:0]    clr;
	logic                    ack_q;
	logic                    acc;
	logic                    wr;
	logic [31:0]             rd;
	logic                    ext_path;
	logic                    pll_on;
	logic                    shutdown_q;
	logic                    loss;
	logic [9:0]              ref_idle_q;
	logic [9:0]              act_idle_q;
	logic                    stalled;
	logic [8:0]              cnt_q;
	logic                    x2_q;
	logic                    sys_q;
	logic                    tick;
	logic                    period_end;
	logic                    do_switch;

	// Two-flop synchronisers plus one stage for edge detection
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sy1_q <= 4'h0;
			sy2_q <= 4'h0;
			sy3_q <= 4'h0;
		end else begin
			sy1_q <= {pll_clk, external_clock_pin, xtal_osc_clk, relax_osc_clk};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end

	// Any edge of each source, indexed by the source type
	assign edg = sy2_q ^ sy3_q;

	// Bus access decode; one cycle to answer
	assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr = acc & wb_we_i;
	assign clr = (wr && wb_adr_i == `CSU_OFF_INT_CLR) ?
		wb_dat_i[`CSU_EV_W-1:0] : '0;

	// Reference source and requested clock configuration
	always_comb begin
		ext_path = osc_q.external_source_select & osc_q.clk_mode & port_b_peripheral_enable
			& pin_function_select_c0;
		if (!pll_q.ref_sel) begin
			ref_src = SRC_RELAX;
		end else if (ext_path) begin
			ref_src = SRC_EXTERNAL_CLOCK_PIN;
		end else begin
			ref_src = SRC_XTAL;
		end
		pll_on = ~pll_q.pll_pd & ~shutdown_q;
		req.src = (pll_q.pll_use && pll_on) ? SRC_PLL : ref_src;
		req.ratio = (pll_q.ratio > `CSU_RATIO_MAX) ? `CSU_RATIO_MAX :
			pll_q.ratio;
	end

	// Control registers written by software
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pll_q <= pll_unpack(`CSU_RST_PLL_CTRL);
			osc_q <= osc_unpack(`CSU_RST_OSC_CTRL);
		end else if (wr) begin
			if (wb_adr_i == `CSU_OFF_PLL_CTRL) begin
				pll_q <= pll_unpack(merge(pll_pack(pll_q), wb_dat_i, wb_sel_i));
			end else if (wb_adr_i == `CSU_OFF_OSC_CTRL) begin
				osc_q <= osc_unpack(merge(osc_pack(osc_q), wb_dat_i, wb_sel_i));
			end
		end
	end

	// Factory trim captured once after reset release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			opt0_q <= 10'h000;
			opt_loaded_q <= 1'b0;
		end else if (!opt_loaded_q) begin
			opt0_q <= flash_trim_value;
			opt_loaded_q <= 1'b1;
		end
	end

	// Interrupt enable register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en_q <= '0;
		end else if (wr && wb_adr_i == `CSU_OFF_INT_EN) begin
			en_q <= wb_dat_i[`CSU_EV_W-1:0];
		end
	end

	// Sticky event bits; a new event wins over a clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stat_q <= '0;
		end else begin
			stat_q <= (stat_q & ~clr) | ev;
		end
	end

	// Read mux
	always_comb begin
		if (wb_adr_i == `CSU_OFF_PLL_CTRL) begin
			rd = pll_pack(pll_q);
		end else if (wb_adr_i == `CSU_OFF_OSC_CTRL) begin
			rd = osc_pack(osc_q);
		end else if (wb_adr_i == `CSU_OFF_FLASH_OPT0) begin
			rd = {22'h0, opt0_q};
		end else if (wb_adr_i == `CSU_OFF_INT_STAT) begin
			rd = {30'h0, stat_q};
		end else if (wb_adr_i == `CSU_OFF_INT_EN) begin
			rd = {30'h0, en_q};
		end else if (wb_adr_i == `CSU_OFF_STATE) begin
			rd = {24'h0, act_q.ratio, ext_path, stalled, act_q.src};
		end else begin
			rd = 32'h0;
		end
	end

	// Bus answer and read data
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_q <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			ack_q <= acc;
			if (acc && !wb_we_i) begin
				wb_dat_o <= rd;
			end
		end
	end

	// Loss watch on the PLL reference while the PLL runs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_idle_q <= 10'h0;
		end else if (edg[ref_src] || !pll_on) begin
			ref_idle_q <= 10'h0;
		end else if (ref_idle_q != LOSS_CNT) begin
			ref_idle_q <= ref_idle_q + 10'h1;
		end
	end

	assign loss = pll_on && ref_idle_q == LOSS_CNT;

	// Shutdown holds until software drops the PLL use bit; loss wins
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shutdown_q <= 1'b0;
		end else if (loss) begin
			shutdown_q <= 1'b1;
		end else if (wr && wb_adr_i == `CSU_OFF_PLL_CTRL && wb_sel_i[0]
			&& !wb_dat_i[`CSU_PLL_USE]) begin
			shutdown_q <= 1'b0;
		end
	end

	// Activity watch on the clock now driving the postscaler
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			act_idle_q <= 10'h0;
		end else if (edg[act_q.src]) begin
			act_idle_q <= 10'h0;
		end else if (act_idle_q != LOSS_CNT) begin
			act_idle_q <= act_idle_q + 10'h1;
		end
	end

	assign stalled = act_idle_q == LOSS_CNT;

	// Postscaler terminal and end of a full system clock period
	assign tick = edg[act_q.src] && cnt_q == post_term(act_q.ratio);
	assign period_end = tick && x2_q && sys_q;
	// Switch only at a period boundary, or at once if the old clock died
	assign do_switch = (period_end || stalled) && req != act_q;
	assign ev[`CSU_EV_REF_LOST] = loss;
	assign ev[`CSU_EV_SWITCHED] = do_switch;

	// Active configuration
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			act_q.src <= SRC_RELAX;
			act_q.ratio <= 4'h0;
		end else if (do_switch) begin
			act_q <= req;
		end
	end

	// Postscaler counter counts source edges
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 9'h0;
		end else if (do_switch || tick) begin
			cnt_q <= 9'h0;
		end else if (edg[act_q.src]) begin
			cnt_q <= cnt_q + 9'h1;
		end
	end

	// Double-rate clock and system clock toggles
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			x2_q <= 1'b0;
			sys_q <= 1'b0;
		end else if (do_switch) begin
			x2_q <= 1'b0;
			sys_q <= 1'b0;
		end else if (tick) begin
			x2_q <= ~x2_q;
			if (x2_q) begin
				sys_q <= ~sys_q;
			end
		end
	end

	// Outputs to the analog sources and the rest of the chip
	assign wb_ack_o = ack_q;
	assign relax_osc_power_down = osc_q.relax_pd;
	assign relax_osc_standby = osc_q.relax_sb & ~osc_q.relax_pd;
	assign xtal_osc_power_down = osc_q.xtal_pd;
	assign pll_power_down = pll_q.pll_pd | shutdown_q;
	assign relax_osc_trim = osc_q.trim;
	assign external_clock_route = ext_path;
	assign active_source = act_q.src;
	assign sys_clk = sys_q;
	assign sys_clk_2x = x2_q;
	assign ref_lost = shutdown_q;
	assign irq = |(stat_q & en_q);

endmodule

// ### hdl/csu_cfg.svh
// Offsets, field positions, reset values and timing counts of the clock unit
`ifndef CSU_CFG_SVH
`define CSU_CFG_SVH

// Register byte offsets
`define CSU_OFF_PLL_CTRL   8'h00
`define CSU_OFF_OSC_CTRL   8'h04
`define CSU_OFF_FLASH_OPT0 8'h08
`define CSU_OFF_INT_STAT   8'h0c
`define CSU_OFF_INT_CLR    8'h10
`define CSU_OFF_INT_EN     8'h14
`define CSU_OFF_STATE      8'h18

// pll_control_reg fields
`define CSU_PLL_REF_SEL    0
`define CSU_PLL_USE        1
`define CSU_PLL_PD         2
`define CSU_PLL_RATIO_LSB  4
`define CSU_PLL_RATIO_MSB  7

// oscillator_control_reg fields
`define CSU_OSC_TRIM_LSB   0
`define CSU_OSC_TRIM_MSB   9
`define CSU_OSC_RELAX_PD   10
`define CSU_OSC_RELAX_SB   11
`define CSU_OSC_XTAL_PD    12
`define CSU_OSC_EXTERNAL_SOURCE_SELECT    13
`define CSU_OSC_CLK_MODE   14

// Reset values
`define CSU_RST_PLL_CTRL   32'h0000_0004
`define CSU_RST_OSC_CTRL   32'h0000_0000

// Interrupt events
`define CSU_EV_REF_LOST    0
`define CSU_EV_SWITCHED    1
`define CSU_EV_W           2

// Postscaler limits
`define CSU_RATIO_MAX      4'h8

// Timing
`define CSU_CLK_PERIOD_NS  8
`define CSU_LOSS_TIME_NS   5000
`define CSU_LOSS_CYC \
	((`CSU_LOSS_TIME_NS + `CSU_CLK_PERIOD_NS - 1) / `CSU_CLK_PERIOD_NS)

`endif

// ### hdl/csu_pkg.sv
// Types shared by the clock synthesis unit
package csu_pkg;

	typedef enum logic [1:0] {
		SRC_RELAX,
		SRC_XTAL,
		SRC_EXTERNAL_CLOCK_PIN,
		SRC_PLL
	} csu_src_type;

	typedef struct packed {
		logic [3:0] ratio;
		logic       pll_pd;
		logic       pll_use;
		logic       ref_sel;
	} csu_pll_ctrl_type;

	typedef struct packed {
		logic       clk_mode;
		logic       external_source_select;
		logic       xtal_pd;
		logic       relax_sb;
		logic       relax_pd;
		logic [9:0] trim;
	} csu_osc_ctrl_type;

	typedef struct packed {
		csu_src_type src;
		logic [3:0]  ratio;
	} csu_clk_cfg_type;

endpackage

// ### test/csu_clock_synthesis_asserts.sv
// Port-level checks of the clock synthesis unit
`include "csu_cfg.svh"
module csu_clock_synthesis_asserts (
	input wire logic                 clk,
	input wire logic                 reset_n,
	input wire logic                 wb_cyc_i,
	input wire logic                 wb_stb_i,
	input wire logic                 wb_we_i,
	input wire logic [7:0]           wb_adr_i,
	input wire logic [3:0]           wb_sel_i,
	input wire logic [31:0]          wb_dat_i,
	input wire logic                 wb_ack_o,
	input wire logic                 port_b_peripheral_enable,
	input wire logic                 pin_function_select_c0,
	input wire logic                 relax_osc_power_down,
	input wire logic                 relax_osc_standby,
	input wire logic                 xtal_osc_power_down,
	input wire logic                 pll_power_down,
	input wire logic [9:0]           relax_osc_trim,
	input wire logic                 external_clock_route,
	input wire csu_pkg::csu_src_type active_source,
	input wire logic                 sys_clk,
	input wire logic                 sys_clk_2x,
	input wire logic                 ref_lost
);
	import csu_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Write cycles taken by the oscillator and PLL control registers
	sequence s_take;
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	endsequence
	sequence s_osc_wr;
		s_take ##0 wb_adr_i == `CSU_OFF_OSC_CTRL && wb_sel_i[1:0] == 2'h3;
	endsequence
	sequence s_pll_pd_wr;
		s_take ##0 wb_adr_i == `CSU_OFF_PLL_CTRL && wb_sel_i[0] && wb_dat_i[2];
	endsequence

	AST_RESET_STATE: assert property (
		$rose(reset_n) |-> active_source == SRC_RELAX && pll_power_down)
		else $error("Source or PLL state wrong after reset");
	AST_SYS_ON_2X_FALL: assert property (
		$rose(sys_clk) |-> $fell(sys_clk_2x))
		else $error("System clock rose without a double-rate fall");
	AST_2X_NOT_WITH_SYS: assert property (
		$changed(sys_clk) |-> !$rose(sys_clk_2x))
		else $error("System clock moved on a double-rate rise");
	AST_SYS_HIGH_MIN: assert property (
		$rose(sys_clk) |=> sys_clk)
		else $error("Shortened system clock pulse");
	AST_EXT_ROUTE: assert property (
		external_clock_route |-> port_b_peripheral_enable
			&& pin_function_select_c0)
		else $error("Clock pin routed without pin setup");
	AST_TRIM_WRITE: assert property (
		s_osc_wr |=> relax_osc_trim == wb_dat_i[9:0])
		else $error("Trim output does not follow write");
	AST_OSC_STATE_WRITE: assert property (
		s_osc_wr |=> relax_osc_power_down == wb_dat_i[10]
			&& relax_osc_standby == (wb_dat_i[11] && !wb_dat_i[10])
			&& xtal_osc_power_down == wb_dat_i[12])
		else $error("Oscillator state outputs do not follow write");
	AST_PLL_PD_WRITE: assert property (
		s_pll_pd_wr |=> pll_power_down)
		else $error("PLL not powered down after write");
	AST_LOST_SHUTS_PLL: assert property (
		ref_lost |-> pll_power_down)
		else $error("PLL running with reference lost");
endmodule

// ### test/csu_src_model.sv
// Behavioural oscillators and external clock source
module csu_src_model (
	input  wire logic relax_osc_power_down,
	input  wire logic relax_osc_standby,
	input  wire logic xtal_osc_power_down,
	input  wire logic pll_power_down,
	output logic      relax_osc_clk,
	output logic      xtal_osc_clk,
	output logic      external_clock_pin,
	output logic      pll_clk
);
	timeunit 1ns;
	timeprecision 100ps;
	// Relaxation oscillator: run, standby at one twentieth, or off low
	initial begin
		relax_osc_clk = 1'b0;
		#3;
		forever begin
			#(relax_osc_standby ? 640 : 32);
			relax_osc_clk = !relax_osc_power_down && !relax_osc_clk;
		end
	end
	// Crystal oscillator, stands still low when off
	initial begin
		xtal_osc_clk = 1'b0;
		#3;
		forever #48 xtal_osc_clk = !xtal_osc_power_down && !xtal_osc_clk;
	end
	// External clock well below its ceiling, and the PLL output
	initial begin
		external_clock_pin = 1'b0;
		pll_clk = 1'b0;
		#3;
		fork
			forever #24 external_clock_pin = !external_clock_pin;
			forever #16 pll_clk = !pll_power_down && !pll_clk;
		join
	end
endmodule

// ### test/csu_clock_synthesis_tb.sv
// Self-checking bench for the clock synthesis unit
`include "csu_cfg.svh"
module csu_clock_synthesis_tb;
	import csu_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0] wb_adr_i = 0;
	logic [3:0] wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, q;
	logic wb_ack_o, relax_osc_clk, xtal_osc_clk, external_clock_pin, pll_clk;
	logic port_b_peripheral_enable = 0, pin_function_select_c0 = 0;
	logic [9:0] flash_trim_value, relax_osc_trim;
	logic relax_osc_power_down, relax_osc_standby, xtal_osc_power_down;
	logic pll_power_down, external_clock_route, sys_clk, sys_clk_2x;
	logic ref_lost, irq;
	csu_src_type active_source;
	integer seed = 32'hfde7;
	int err_count = 0, tests_run = 0, cycles = 0, osc_m, r, hi, per, x2;
	int ratios[5] = '{0, 1, 2, 8, 15};

	always #4 clk = !clk;
	csu_clock_synthesis #(.LOSS_CYCLES(20)) dut (.clk, .reset_n, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .relax_osc_clk, .xtal_osc_clk, .external_clock_pin,
		.pll_clk, .port_b_peripheral_enable, .pin_function_select_c0,
		.flash_trim_value, .relax_osc_power_down, .relax_osc_standby,
		.xtal_osc_power_down, .pll_power_down, .relax_osc_trim,
		.external_clock_route, .active_source, .sys_clk, .sys_clk_2x,
		.ref_lost, .irq);
	csu_src_model u_src (.relax_osc_power_down, .relax_osc_standby,
		.xtal_osc_power_down, .pll_power_down, .relax_osc_clk,
		.xtal_osc_clk, .external_clock_pin, .pll_clk);

	task automatic summarize;
		$display("Mismatches %0d, checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One classic Wishbone cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(q, exp);
	endtask
	// Period, high time and double-rate rises of one system clock period
	task automatic measure;
		logic p, s, p2;
		while (sys_clk !== 1'b0) @(posedge clk);
		while (sys_clk !== 1'b1) @(posedge clk);
		per = 0; hi = 0; x2 = 0; s = 1'b1; p2 = sys_clk_2x;
		do begin
			hi += sys_clk;
			@(posedge clk);
			per++;
			x2 += sys_clk_2x & !p2;
			p2 = sys_clk_2x;
			p = s;
			s = sys_clk;
		end while (!(s && !p));
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			summarize;
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		flash_trim_value <= 10'($random(seed));
		reset_n <= 1'b1;
		rd_chk(`CSU_OFF_PLL_CTRL, `CSU_RST_PLL_CTRL);
		check(active_source, SRC_RELAX);
		rd_chk(`CSU_OFF_FLASH_OPT0, flash_trim_value);
		// Boot code copies the factory trim into the trim field
		wb(1'b1, `CSU_OFF_OSC_CTRL, q);
		check(relax_osc_trim, flash_trim_value);
		rd_chk(8'h20, 32'h0);
		// Random trims and oscillator states
		repeat (4) begin
			osc_m = $random(seed) & 32'h1fff;
			wb(1'b1, `CSU_OFF_OSC_CTRL, osc_m);
			check(relax_osc_trim, osc_m[9:0]);
			check(relax_osc_power_down, osc_m[10]);
			check(relax_osc_standby, osc_m[11] & !osc_m[10]);
			check(xtal_osc_power_down, osc_m[12]);
			rd_chk(`CSU_OFF_OSC_CTRL, osc_m);
		end
		wb(1'b1, `CSU_OFF_OSC_CTRL, 32'h0);
		// Postscaler ratios, the top one past the last legal setting
		foreach (ratios[i]) begin
			wb(1'b1, `CSU_OFF_PLL_CTRL, 32'h4 | (ratios[i] << 4));
			r = ratios[i] > 8 ? 8 : ratios[i];
			measure;
			measure;
			check(per, 16 << r);
			check(hi, 8 << r);
			check(x2, 2);
		end
		// Reference lost while the PLL is in use
		wb(1'b1, `CSU_OFF_INT_EN, 32'h1);
		wb(1'b1, `CSU_OFF_PLL_CTRL, 32'h2);
		// Switch waits for the end of the slow period still running
		while (active_source !== SRC_PLL) @(posedge clk);
		repeat (60) @(posedge clk);
		check({pll_power_down, ref_lost, active_source}, SRC_PLL);
		wb(1'b1, `CSU_OFF_OSC_CTRL, 32'h400);
		repeat (12) @(posedge clk);
		check(ref_lost, 1'b0);
		repeat (60) @(posedge clk);
		check({pll_power_down, ref_lost, irq}, 3'h7);
		check(active_source == SRC_PLL, 1'b0);
		wb(1'b0, `CSU_OFF_INT_STAT, 32'h0);
		check(q[0], 1'b1);
		wb(1'b1, `CSU_OFF_INT_EN, 32'h0);
		@(posedge clk);
		check(irq, 1'b0);
		wb(1'b1, `CSU_OFF_INT_CLR, 32'h3);
		wb(1'b1, `CSU_OFF_INT_EN, 32'h3);
		@(posedge clk);
		check(irq, 1'b0);
		rd_chk(`CSU_OFF_INT_STAT, 32'h0);
		wb(1'b1, `CSU_OFF_OSC_CTRL, 32'h0);
		wb(1'b1, `CSU_OFF_PLL_CTRL, 32'h4);
		check(ref_lost, 1'b0);
		// External pin: source bits enabled first, then reference select
		wb(1'b1, `CSU_OFF_OSC_CTRL, 32'h6000);
		wb(1'b1, `CSU_OFF_PLL_CTRL, 32'h5);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			port_b_peripheral_enable <= k[0];
			pin_function_select_c0 <= k[1];
			repeat (80) @(posedge clk);
			check(external_clock_route, k == 3);
			check(active_source, k == 3 ? SRC_EXTERNAL_CLOCK_PIN : SRC_XTAL);
			rd_chk(`CSU_OFF_STATE, k == 3 ? 32'ha : 32'h1);
		end
		summarize;
	end
endmodule

bind csu_clock_synthesis csu_clock_synthesis_asserts u_ast (.clk, .reset_n,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_ack_o, .port_b_peripheral_enable, .pin_function_select_c0,
	.relax_osc_power_down, .relax_osc_standby, .xtal_osc_power_down,
	.pll_power_down, .relax_osc_trim, .external_clock_route,
	.active_source, .sys_clk, .sys_clk_2x, .ref_lost);
